// ---- src/psrb_pkg.sv ----
// Constants and types shared by the process scheduler and its buffer arbiter
// Function
// RULE_01: Sixteen 1536-byte buffers inside 16K-word store
// RULE_02: First four bytes of each buffer hold status
// RULE_03: Four requesters arbitrate for buffer memory
// RULE_04: Interrupt sets request bit, process not run
// RULE_05: Idle loop scans request bits and dispatches
// RULE_06: Fixed priority receive, command, timer, loop, transmit
// RULE_07: Low processes run at level zero, no switching
// RULE_08: Dispatched process completes before next scan
// RULE_09: Completion by interrupt return or command-complete
// RULE_10: Receive at level five, only abort events preempt
// RULE_11: Receive triggered by buffer-filled, start or poll
// RULE_12: Receive polls ring, starts DMA, returns on done
// RULE_13: Receive ends after status and next descriptor
// RULE_14: Other processes may run while receive DMA runs
// RULE_15: Dispatch table copied from ROM into control store
// RULE_16: Initialisation sequence ends in idle at level zero
// RULE_17: Best pending rank first, its bit cleared
package psrb_pkg;
   // Buffer memory geometry
   localparam int NUM_BUF        = 16;
   localparam int BUF_BYTES      = 1536;
   localparam int STORE_WORDS    = 16384;
   localparam int BYTES_PER_WORD = 2;
   localparam int HDR_BYTES      = 4;
   localparam int BUF_WORDS      = BUF_BYTES / BYTES_PER_WORD;
   localparam int HDR_WORDS      = HDR_BYTES / BYTES_PER_WORD;
   localparam int LM_AW          = $clog2(STORE_WORDS);
   localparam int BUF_IW         = $clog2(NUM_BUF);
   localparam int OFF_W          = $clog2(BUF_WORDS);
   // Buffer memory requesters, index is also arbitration rank
   localparam int NUM_REQ = 4;
   localparam int REQ_RX  = 0;
   localparam int REQ_TX  = 1;
   localparam int REQ_DMA = 2;
   localparam int REQ_CPU = 3;
   // Scheduled processes, lower index is better rank
   localparam int NUM_PROC = 5;
   localparam int P_RX     = 0;
   localparam int P_CMD    = 1;
   localparam int P_TIMER  = 2;
   localparam int P_LOOP   = 3;
   localparam int P_TX     = 4;
   // Processor priority levels
   localparam int             IPL_W   = 3;
   localparam logic [IPL_W-1:0] IPL_LOW = 3'h0;
   localparam logic [IPL_W-1:0] IPL_RX  = 3'h5;
   // Dispatch table: one entry per process plus command-complete
   localparam int DSP_N = NUM_PROC + 1;
   localparam int DSP_W = 8;
   localparam int CNT_W = 3;
   localparam logic [CNT_W-1:0] CNT_LAST = 3'h5;
   // Routine entry points held in ROM
   localparam logic [DSP_N-1:0][DSP_W-1:0] DSP_ROM =
      {8'hF0, 8'h50, 8'h40, 8'h30, 8'h20, 8'h10};

   // Supervisor states
   typedef enum logic [7:0] {
      S_RST   = 8'h01,
      S_COPY  = 8'h02,
      S_CLEAR = 8'h04,
      S_ADDR  = 8'h08,
      S_BUFS  = 8'h10,
      S_IDLE  = 8'h20,
      S_RUN   = 8'h40,
      S_SPARE = 8'h80
   } psrb_sup_t;

   // Receive process states
   typedef enum logic [5:0] {
      R_IDLE = 6'h01,
      R_POLL = 6'h02,
      R_LOAD = 6'h04,
      R_WAIT = 6'h08,
      R_STAT = 6'h10,
      R_NEXT = 6'h20
   } psrb_rx_t;
endpackage

// ---- src/psrb_arb_if.sv ----
// Request and grant carrier between the scheduler and the buffer arbiter
interface psrb_arb_if #(parameter int N = 4);
   logic [N-1:0] req;  // One request per requester
   logic [N-1:0] gnt;  // One-hot grant
   modport arb  (input req, output gnt);
   modport user (output req, input gnt);
endinterface

// ---- src/psrb_arbiter.sv ----
// Fixed-rank buffer memory arbiter with grant held until release
module psrb_arbiter
   import psrb_pkg::*;
#(
   parameter int N = NUM_REQ
) (
   input  wire logic clk_sys,
   input  wire logic reset_n,
   psrb_arb_if.arb   bus
);
   // All state of the arbiter
   typedef struct packed {
      logic [N-1:0] gnt;
   } psrb_arb_state_t;

   psrb_arb_state_t st;       // Registered state
   psrb_arb_state_t next_st;  // Next state

   // Keep the current owner while it asks, else pick best rank
   always_comb begin
      next_st = st;
      if ((st.gnt & bus.req) == '0) begin
         next_st.gnt = '0;
         for (int i = N - 1; i >= 0; i--) begin
            if (bus.req[i]) begin
               next_st.gnt = '0;
               next_st.gnt[i] = 1'b1;  // RULE_03
            end
         end
      end
   end

   // State register
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign bus.gnt = st.gnt;
endmodule

// ---- src/psrb_scheduler.sv ----
// Supervisor scheduler, receive process and link buffer address path
module psrb_scheduler
   import psrb_pkg::*;
(
   input  wire logic                              clk_sys,
   input  wire logic                              reset_n,
   input  wire logic                              selftest_done,
   input  wire logic                              irq_rx_filled,
   input  wire logic [psrb_pkg::BUF_IW-1:0]       rx_filled_buf,
   input  wire logic                              irq_host_start,
   input  wire logic                              irq_host_poll,
   input  wire logic                              irq_port_cmd,
   input  wire logic                              irq_timer,
   input  wire logic                              irq_loop,
   input  wire logic                              irq_tx,
   input  wire logic                              irq_dma_done,
   input  wire logic                              irq_power_fail,
   input  wire logic                              irq_error,
   input  wire logic                              return_from_interrupt,
   input  wire logic                              cmd_complete,
   input  wire logic                              station_ack,
   input  wire logic                              ring_ack,
   input  wire logic                              ring_buf_ok,
   input  wire logic                              desc_ack,
   input  wire logic [psrb_pkg::NUM_REQ-1:0]      lm_req,
   input  wire logic [psrb_pkg::NUM_REQ-1:0][psrb_pkg::BUF_IW-1:0] lm_buf,
   input  wire logic [psrb_pkg::NUM_REQ-1:0]      lm_hdr,
   input  wire logic [psrb_pkg::NUM_REQ-1:0][psrb_pkg::OFF_W-1:0]  lm_off,
   output logic                                   init_busy,
   output logic                                   hw_reset,
   output logic                                   clear_stats,
   output logic                                   station_load,
   output logic                                   irq_enabled,
   output logic [psrb_pkg::IPL_W-1:0]             ipl,
   output logic [psrb_pkg::NUM_PROC-1:0]          proc_run,
   output logic [psrb_pkg::DSP_W-1:0]             proc_entry,
   output logic                                   low_hold,
   output logic                                   ring_poll_req,
   output logic                                   dma_start,
   output logic [psrb_pkg::LM_AW-1:0]             dma_lm_addr,
   output logic                                   desc_status_wr,
   output logic                                   desc_next_rd,
   output logic                                   rx_fault,
   output logic [psrb_pkg::NUM_BUF-1:0]           free_bufs,
   output logic [psrb_pkg::NUM_REQ-1:0]           lm_gnt,
   output logic [psrb_pkg::LM_AW-1:0]             lm_addr
);
   import psrb_pkg::*;

   // All state of the scheduler
   typedef struct packed {
      psrb_sup_t                    sup;       // Supervisor step
      psrb_rx_t                     rx;        // Receive process step
      logic [NUM_PROC-1:0]          mask;      // Pending requests
      logic [NUM_PROC-1:0]          run;       // Dispatched low process
      logic [DSP_N-1:0][DSP_W-1:0]  writable_control_store;       // Writable dispatch table
      logic [CNT_W-1:0]             cnt;       // Copy index
      logic [DSP_W-1:0]             entry;     // Entry of running process
      logic                         irq_en;    // Interrupts accepted
      logic                         hw_reset;  // Hardware reset strobe
      logic                         clr;       // Counter clear strobe
      logic                         sta_load;  // Station address load
      logic [IPL_W-1:0]             ipl;       // Processor level
      logic                         hold;      // Low process suspended
      logic                         ring_req;  // Ring poll request
      logic                         dma_go;    // DMA start strobe
      logic                         stat_wr;   // Descriptor status write
      logic                         next_rd;   // Next descriptor read
      logic                         fault;     // Receive aborted
      logic [BUF_IW-1:0]            rx_buf;    // Buffer being drained
      logic [LM_AW-1:0]             dma_addr;  // DMA source word
      logic [NUM_BUF-1:0]           free;      // Buffers free for the link
      logic [LM_AW-1:0]             lm_addr;   // Granted word address
      logic                         busy;      // Setup not finished
   } psrb_state_t;

   localparam psrb_state_t ST_RESET = '{
      sup: S_RST, rx: R_IDLE, ipl: IPL_LOW, hw_reset: 1'b1, busy: 1'b1, default: '0};

   psrb_state_t st;       // Registered state
   psrb_state_t next_st;  // Next state

   // Arbiter link
   psrb_arb_if #(.N(NUM_REQ)) arb_bus ();

   assign arb_bus.req = lm_req;

   psrb_arbiter #(.N(NUM_REQ)) u_arb (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .bus     (arb_bus)
   );

   // Combined event terms
   logic                abort;    // Events that may preempt receive
   logic                live;     // Supervisor has finished setup
   logic                done;     // Low process handed back
   logic [NUM_PROC-1:0] set_v;    // Request bits raised this cycle

   assign abort = irq_power_fail | irq_error;
   assign live  = (st.sup == S_IDLE) || (st.sup == S_RUN);
   assign done  = return_from_interrupt | cmd_complete;
   // Start and poll commands share the receive bit with buffer-filled
   assign set_v = st.irq_en ?
      {irq_tx, irq_loop, irq_timer, irq_port_cmd,
       irq_rx_filled | irq_host_start | irq_host_poll} : '0;  // RULE_11

   // Next-state logic for supervisor, receive process and address path
   always_comb begin
      int                sel;
      logic [LM_AW-1:0]  word;
      sel = NUM_PROC;
      word = '0;
      next_st = st;
      next_st.hw_reset = 1'b0;
      next_st.clr = 1'b0;
      next_st.dma_go = 1'b0;

      // Supervisor sequence
      unique case (st.sup)
         // Held in reset until self-test ends
         S_RST: begin
            next_st.hw_reset = 1'b1;
            if (selftest_done) begin
               next_st.hw_reset = 1'b0;
               next_st.cnt = '0;
               next_st.sup = S_COPY;
            end
         end
         // One dispatch entry per cycle from ROM
         S_COPY: begin
            next_st.writable_control_store[st.cnt] = DSP_ROM[st.cnt];  // RULE_15
            next_st.cnt = st.cnt + 1'b1;
            if (st.cnt == CNT_LAST) begin
               next_st.sup = S_CLEAR;
            end
         end
         // Clear counters, mode and rings; ask for station address
         S_CLEAR: begin
            next_st.clr = 1'b1;  // RULE_16
            next_st.mask = '0;
            next_st.fault = 1'b0;
            next_st.sta_load = 1'b1;
            next_st.sup = S_ADDR;
         end
         // Wait for the address memory, then open interrupts
         S_ADDR: begin
            if (station_ack) begin
               next_st.sta_load = 1'b0;
               next_st.irq_en = 1'b1;  // RULE_16
               next_st.sup = S_BUFS;
            end
         end
         // Hand every buffer to the link and start idling
         S_BUFS: begin
            next_st.free = '1;
            next_st.ipl = IPL_LOW;  // RULE_16
            next_st.busy = 1'b0;
            next_st.sup = S_IDLE;
         end
         // Idle loop scans the mask for the best pending rank
         S_IDLE: begin
            for (int i = NUM_PROC - 1; i >= P_CMD; i--) begin
               if (st.mask[i]) begin
                  sel = i;  // RULE_06
               end
            end
            if (sel != NUM_PROC && !st.hold) begin
               next_st.mask[sel] = 1'b0;  // RULE_17
               next_st.run = '0;
               next_st.run[sel] = 1'b1;  // RULE_05
               next_st.entry = st.writable_control_store[sel];
               next_st.sup = S_RUN;
            end
         end
         // Run to completion; no rescan while the process owns the CPU
         S_RUN: begin
            if (done && !st.hold) begin
               next_st.run = '0;  // RULE_09
               next_st.entry = st.writable_control_store[NUM_PROC];
               next_st.sup = S_IDLE;  // RULE_08
            end
         end
         // Illegal code falls back to a fresh start
         default: begin
            next_st = ST_RESET;
         end
      endcase

      // Receive process at interrupt level
      unique case (st.rx)
         // Preempts a low process immediately, no idle scan needed
         R_IDLE: begin
            if (live && st.mask[P_RX]) begin
               next_st.mask[P_RX] = 1'b0;
               next_st.ipl = IPL_RX;  // RULE_10
               next_st.hold = 1'b1;  // RULE_07
               next_st.ring_req = 1'b1;  // RULE_12
               next_st.rx = R_POLL;
            end
         end
         // Host ring poll for a free host buffer
         R_POLL: begin
            if (ring_ack) begin
               next_st.ring_req = 1'b0;
               if (ring_buf_ok) begin
                  next_st.rx = R_LOAD;
               end else begin
                  next_st.ipl = IPL_LOW;
                  next_st.hold = 1'b0;
                  next_st.rx = R_IDLE;
               end
            end
         end
         // DMA loaded with the packet body behind the header
         R_LOAD: begin
            next_st.dma_go = 1'b1;  // RULE_12
            next_st.dma_addr = LM_AW'(st.rx_buf) * LM_AW'(BUF_WORDS)
                             + LM_AW'(HDR_WORDS);  // RULE_02
            next_st.ipl = IPL_LOW;
            next_st.hold = 1'b0;  // RULE_14
            next_st.rx = R_WAIT;
         end
         // Low processes are free to run until DMA finishes
         R_WAIT: begin
            if (irq_dma_done) begin
               next_st.ipl = IPL_RX;
               next_st.hold = 1'b1;
               next_st.stat_wr = 1'b1;  // RULE_13
               next_st.rx = R_STAT;
            end
         end
         // Status into the host descriptor
         R_STAT: begin
            if (desc_ack) begin
               next_st.stat_wr = 1'b0;
               next_st.next_rd = 1'b1;  // RULE_13
               next_st.rx = R_NEXT;
            end
         end
         // Next descriptor fetched; buffer goes back to the link
         R_NEXT: begin
            if (desc_ack) begin
               next_st.next_rd = 1'b0;
               next_st.free[st.rx_buf] = 1'b1;
               next_st.ipl = IPL_LOW;  // RULE_12
               next_st.hold = 1'b0;
               next_st.rx = R_IDLE;
            end
         end
      endcase

      // Power failure or error abandons the receive in flight
      if (abort && st.rx != R_IDLE) begin
         next_st.fault = 1'b1;  // RULE_10
         next_st.ring_req = 1'b0;
         next_st.dma_go = 1'b0;
         next_st.stat_wr = 1'b0;
         next_st.next_rd = 1'b0;
         next_st.ipl = IPL_LOW;
         next_st.hold = 1'b0;
         next_st.rx = R_IDLE;
      end

      // A filled buffer is owned by the receive path until drained
      if (irq_rx_filled && st.irq_en) begin
         next_st.free[rx_filled_buf] = 1'b0;
         next_st.rx_buf = rx_filled_buf;
      end

      // New requests win over a clear in the same cycle
      next_st.mask = next_st.mask | set_v;  // RULE_04

      // Word address of the granted requester; header pinned to words 0-1
      for (int g = 0; g < NUM_REQ; g++) begin
         if (arb_bus.gnt[g]) begin
            word = lm_hdr[g] ? LM_AW'(lm_off[g][0])
                             : LM_AW'(lm_off[g]) + LM_AW'(HDR_WORDS);  // RULE_02
            next_st.lm_addr = LM_AW'(lm_buf[g]) * LM_AW'(BUF_WORDS) + word;  // RULE_01
         end
      end
   end

   // State register
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from state
   assign init_busy      = st.busy;
   assign hw_reset       = st.hw_reset;
   assign clear_stats    = st.clr;
   assign station_load   = st.sta_load;
   assign irq_enabled    = st.irq_en;
   assign ipl            = st.ipl;
   assign proc_run       = st.run;
   assign proc_entry     = st.entry;
   assign low_hold       = st.hold;
   assign ring_poll_req  = st.ring_req;
   assign dma_start      = st.dma_go;
   assign dma_lm_addr    = st.dma_addr;
   assign desc_status_wr = st.stat_wr;
   assign desc_next_rd   = st.next_rd;
   assign rx_fault       = st.fault;
   assign free_bufs      = st.free;
   assign lm_gnt         = arb_bus.gnt;
   assign lm_addr        = st.lm_addr;

   // Checks on scheduling and buffer access
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   localparam int BUF_SPAN = NUM_BUF * BUF_WORDS;

   // Receive entered from a pending request
   sequence seq_rx_trigger;
      live && st.rx == R_IDLE && st.mask[P_RX] && !abort;
   endsequence

   // DMA finish seen while waiting
   sequence seq_dma_finish;
      st.rx == R_WAIT && irq_dma_done && !abort;
   endsequence

   AST_BUF_SPAN: assert property (lm_addr < BUF_SPAN)  // RULE_01
      else $error("buffer word address beyond sixteen buffers");
   AST_DMA_HDR: assert property (dma_start |-> dma_lm_addr % BUF_WORDS == HDR_WORDS)  // RULE_02
      else $error("DMA does not start past the status header");
   AST_GNT_ONE: assert property ($onehot0(lm_gnt))  // RULE_03
      else $error("more than one buffer memory grant");
   AST_MASK_SET: assert property (irq_timer && st.irq_en |=> st.mask[P_TIMER] || st.run[P_TIMER])  // RULE_04
      else $error("timer request not recorded");
   AST_SCAN: assert property (st.sup == S_IDLE && !st.hold && (|st.mask[P_TX:P_CMD]) |=> st.sup == S_RUN)  // RULE_05
      else $error("idle loop did not dispatch a pending process");
   AST_PRIO: assert property (st.sup == S_IDLE && !st.hold && st.mask[P_CMD] |=> proc_run[P_CMD])  // RULE_06
      else $error("port command not dispatched first");
   AST_LOW_IPL: assert property (st.sup == S_RUN && st.rx == R_IDLE |-> ipl == IPL_LOW)  // RULE_07
      else $error("low process not at level zero");
   AST_RUN_HOLD: assert property (st.sup == S_RUN && !done |=> st.sup == S_RUN && $stable(proc_run))  // RULE_08
      else $error("process left before completion");
   AST_RETURN: assert property (st.sup == S_RUN && done && !st.hold |=> st.sup == S_IDLE && proc_run == '0)  // RULE_09
      else $error("completion did not return to the idle loop");
   AST_RX_LEVEL: assert property (seq_rx_trigger |=> ipl == IPL_RX && low_hold && ring_poll_req)  // RULE_10
      else $error("receive not started at level five");
   AST_RX_DMA: assert property (st.rx == R_LOAD && !abort |=> dma_start ##1 !dma_start)  // RULE_12
      else $error("DMA start not a single strobe");
   AST_RX_END: assert property (seq_dma_finish |=> desc_status_wr && st.rx == R_STAT)  // RULE_13
      else $error("status write missing after DMA done");
   AST_DMA_FREE: assert property (st.rx == R_WAIT |-> !low_hold && ipl == IPL_LOW)  // RULE_14
      else $error("low processes blocked during receive DMA");
   AST_TABLE: assert property (st.sup == S_CLEAR |-> st.writable_control_store == DSP_ROM)  // RULE_15
      else $error("dispatch table copy incomplete");
   AST_INIT_IRQ: assert property (st.sup == S_ADDR && station_ack |=> irq_enabled ##1 st.sup == S_IDLE)  // RULE_16
      else $error("initialisation did not enable interrupts then idle");
endmodule

// ---- tb/psrb_far_model.sv ----
// Far-side model: station memory, host ring, descriptors and DMA engine
module psrb_far_model
(
   input  wire logic clk_sys,
   input  wire logic reset_n,
   input  wire logic slow,
   input  wire logic ok,
   input  wire logic station_load,
   input  wire logic ring_poll_req,
   input  wire logic desc_status_wr,
   input  wire logic desc_next_rd,
   input  wire logic dma_start,
   output logic      station_ack,
   output logic      ring_ack,
   output logic      ring_buf_ok,
   output logic      desc_ack,
   output logic      irq_dma_done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt;  // Cycles spent on the open request
   logic [3:0] dcnt; // DMA transfer time left
   wire  logic [3:0] lim = slow ? 4'h8 : 4'h1;  // Answer delay
   wire  logic any = station_load | ring_poll_req | desc_status_wr | desc_next_rd;

   // One request open at a time; ring answer bit is noise outside an answer
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         {cnt, dcnt, station_ack, ring_ack, desc_ack, ring_buf_ok, irq_dma_done} <= '0;
      end else begin
         {station_ack, ring_ack, desc_ack} <= 3'h0;
         ring_buf_ok <= ~ring_buf_ok;
         if (!any || station_ack || ring_ack || desc_ack) begin
            cnt <= 4'h0;
         end else if (cnt == lim) begin
            cnt <= 4'h0;
            station_ack <= station_load;
            ring_ack <= ring_poll_req;
            desc_ack <= desc_status_wr | desc_next_rd;
            ring_buf_ok <= ok;
         end else begin
            cnt <= cnt + 4'h1;
         end
         // Transfer runs a few cycles, then one done pulse
         if (dma_start) dcnt <= lim + 4'h2;
         else if (dcnt != 4'h0) dcnt <= dcnt - 4'h1;
         irq_dma_done <= (dcnt == 4'h1);
      end
   end
endmodule

// ---- tb/process_scheduler_rx_buffer_test.sv ----
// Self-checking bench for the scheduler, receive path and buffer addressing
module process_scheduler_rx_buffer_test;
   timeunit 1ns;
   timeprecision 1ps;
   import psrb_pkg::*;
   logic clk_sys = 1'b0, reset_n = 1'b0, selftest_done = 1'b0, slow = 1'b0, ok = 1'b1;
   logic [8:0] irqs = '0;  // fill,start,poll,cmd,timer,loop,tx,power,error
   logic [1:0] ret = '0;   // Return, command complete
   logic [3:0] rx_filled_buf = '0, lm_req = '0, lm_hdr = '0, m, g, b;
   logic [NUM_REQ-1:0][BUF_IW-1:0] lm_buf = '0;
   logic [NUM_REQ-1:0][OFF_W-1:0]  lm_off = '0;
   logic station_ack, ring_ack, ring_buf_ok, desc_ack, irq_dma_done, low_hold;
   logic init_busy, hw_reset, clear_stats, station_load, irq_enabled, rx_fault;
   logic ring_poll_req, dma_start, desc_status_wr, desc_next_rd;
   logic [IPL_W-1:0]    ipl;
   logic [NUM_PROC-1:0] proc_run;
   logic [DSP_W-1:0]    proc_entry;
   logic [LM_AW-1:0]    dma_lm_addr, lm_addr;
   logic [NUM_BUF-1:0]  free_bufs;
   logic [NUM_REQ-1:0]  lm_gnt;
   int num_errors = 0, n_tests = 0, t;

   always #5 clk_sys = ~clk_sys;

   psrb_scheduler dut (.clk_sys, .reset_n, .selftest_done, .rx_filled_buf,
      .irq_rx_filled(irqs[0]), .irq_host_start(irqs[1]), .irq_host_poll(irqs[2]),
      .irq_port_cmd(irqs[3]), .irq_timer(irqs[4]), .irq_loop(irqs[5]), .irq_tx(irqs[6]),
      .irq_power_fail(irqs[7]), .irq_error(irqs[8]), .irq_dma_done,
      .return_from_interrupt(ret[0]), .cmd_complete(ret[1]), .station_ack, .ring_ack,
      .ring_buf_ok, .desc_ack, .lm_req, .lm_buf, .lm_hdr, .lm_off, .init_busy, .hw_reset,
      .clear_stats, .station_load, .irq_enabled, .ipl, .proc_run, .proc_entry, .low_hold,
      .ring_poll_req, .dma_start, .dma_lm_addr, .desc_status_wr, .desc_next_rd,
      .rx_fault, .free_bufs, .lm_gnt, .lm_addr);

   psrb_far_model far (.clk_sys, .reset_n, .slow, .ok, .station_load, .ring_poll_req,
      .desc_status_wr, .desc_next_rd, .dma_start, .station_ack, .ring_ack, .ring_buf_ok,
      .desc_ack, .irq_dma_done);

   // Word address of a buffer access: header words, else data after them
   function automatic logic [15:0] exp_addr(int bi, int h, int o);
      return bi * BUF_WORDS + (h != 0 ? o % 2 : o + HDR_WORDS);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   // One-cycle event pulse, launched and dropped on rising edges
   task automatic pulse(input logic [8:0] v, input logic [1:0] r, input logic [3:0] bi);
      @(posedge clk_sys);
      irqs <= v;
      ret <= r;
      rx_filled_buf <= bi;
      @(posedge clk_sys);
      irqs <= '0;
      ret <= '0;
   endtask

   task automatic summarize;
      $display("compares %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Hang guard, well beyond the expected run length
   initial begin
      #500000;
      num_errors++;
      summarize();
   end

   initial begin
      void'($urandom(57250));
      // Reset, an early interrupt that must be lost, then initialisation
      repeat (6) @(negedge clk_sys);
      chk({hw_reset, init_busy, ipl}, {2'b11, IPL_LOW});
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      pulse(9'h010, 2'h0, 4'h0);
      @(posedge clk_sys);
      selftest_done <= 1'b1;
      @(posedge clk_sys);
      selftest_done <= 1'b0;
      @(negedge clk_sys);
      repeat (60) if (init_busy) @(negedge clk_sys);
      chk({init_busy, hw_reset, irq_enabled, ipl}, {3'b001, IPL_LOW});
      repeat (5) @(negedge clk_sys);
      chk(proc_run, 0);
      $display("test init finished");
      // Random batches of low requests, served one at a time by rank
      repeat (12) begin
         m = 4'($urandom_range(1, 15));
         pulse({2'b0, m, 3'b0}, 2'h0, 4'h0);
         for (int p = 1; p < NUM_PROC; p++) if (m[p-1]) begin
            @(negedge clk_sys);
            repeat (10) if (proc_run == 0) @(negedge clk_sys);
            chk(proc_run, 16'(1 << p));
            chk({proc_entry, ipl}, {DSP_ROM[p], IPL_LOW});
            repeat ($urandom_range(1, 6)) @(negedge clk_sys);
            chk(proc_run, 16'(1 << p));
            pulse(9'h0, $urandom_range(0, 1) ? 2'h1 : 2'h2, 4'h0);
            @(negedge clk_sys);
            chk({proc_run, proc_entry}, {5'h0, DSP_ROM[NUM_PROC]});
         end
      end
      $display("test dispatch finished");
      // Receive from every trigger, paced both ways, one ring miss
      for (int k = 0; k < 6; k++) begin
         t = k % 3;
         if (t == 0) b = 4'($urandom);
         ok <= (k != 4);
         slow <= k[0];
         pulse(9'(1 << t), 2'h0, b);
         @(negedge clk_sys);
         repeat (10) if (!ring_poll_req) @(negedge clk_sys);
         chk({ring_poll_req, low_hold, ipl}, {2'b11, IPL_RX});
         if (k == 4) begin
            repeat (20) if (ring_poll_req) @(negedge clk_sys);
            @(negedge clk_sys);
            chk({ipl, dma_start}, 0);
         end else begin
            repeat (20) if (!dma_start) @(negedge clk_sys);
            chk({dma_start, ipl, dma_lm_addr}, {1'b1, IPL_LOW, 14'(exp_addr(b, 0, 0))});
            repeat (20) if (!desc_status_wr) @(negedge clk_sys);
            chk(ipl, IPL_RX);
            repeat (30) if (ipl != IPL_LOW) @(negedge clk_sys);
            chk({desc_status_wr, desc_next_rd, ipl}, 0);
            if (t == 0) chk(free_bufs[b], 1);
         end
      end
      $display("test receive finished");
      // Abort while the ring poll is outstanding
      slow <= 1'b1;
      pulse(9'h001, 2'h0, 4'h3);
      pulse($urandom_range(0, 1) ? 9'h080 : 9'h100, 2'h0, 4'h0);
      @(negedge clk_sys);
      chk({ring_poll_req, dma_start, rx_fault}, 3'b001);
      $display("test abort finished");
      // Random request mixes, then a late better-ranked requester
      repeat (16) begin
         m = 4'($urandom_range(1, 15));
         @(posedge clk_sys);
         lm_req <= m;
         for (int j = 0; j < NUM_REQ; j++) begin
            lm_buf[j] <= 4'($urandom);
            lm_hdr[j] <= 1'($urandom);
            lm_off[j] <= 10'($urandom_range(0, BUF_WORDS - 3));
         end
         repeat (2) @(negedge clk_sys);
         g = m & (~m + 4'h1);
         chk(lm_gnt, g);
         @(negedge clk_sys);
         for (int j = 0; j < NUM_REQ; j++) if (g[j])
            chk(lm_addr, exp_addr(lm_buf[j], lm_hdr[j], lm_off[j]));
         @(posedge clk_sys);
         lm_req <= m | 4'h1;
         repeat (2) @(negedge clk_sys);
         chk(lm_gnt, g);
         @(posedge clk_sys);
         lm_req <= '0;
      end
      $display("test buffer memory finished");
      summarize();
   end
endmodule
